// ==== logic/spc_cfg.svh ====
`ifndef SPC_CFG_SVH
`define SPC_CFG_SVH

// register addresses
`define SPC_A_CFG      16'hC0C8
`define SPC_A_CTL      16'hC0CA
`define SPC_A_IEN      16'hC0CC
`define SPC_A_STS      16'hC0CE
`define SPC_A_CLR      16'hC0D0
`define SPC_A_CRC      16'hC0D2
`define SPC_A_DATA     16'hC0D6

// port configuration fields
`define SPC_CFG_SHARED 15
`define SPC_CFG_ACTIVE 7
`define SPC_CFG_MASTER 6
`define SPC_CFG_SS_EN  5
`define SPC_CFG_DLY    0

// transfer control fields
`define SPC_CTL_INIT   14
`define SPC_CTL_BYTE   13
`define SPC_CTL_FDX    12
`define SPC_CTL_SSMAN  11
`define SPC_CTL_RDEN   10
`define SPC_CTL_TXRDY  9
`define SPC_CTL_RXRDY  8
`define SPC_CTL_TXEMP  7
`define SPC_CTL_RXFUL  6
`define SPC_CTL_TLEN   3
`define SPC_CTL_RLEN   0

// interrupt enable, status and clear fields
`define SPC_IRQ_RX     2
`define SPC_IRQ_TX     1
`define SPC_IRQ_BLK    0
`define SPC_STS_FERR   7

// crc control fields
`define SPC_CRC_MODE   14
`define SPC_CRC_EN     13
`define SPC_CRC_CLR    12
`define SPC_CRC_RX     11
`define SPC_CRC_ONE    10
`define SPC_CRC_ZERO   9

// reset values and constants
`define SPC_SHARED_RST 1'b1
`define SPC_DLY_RST    5'h1F
`define SPC_CRC_PRE    16'hFFFF
`define SPC_CRC7_ONES  7'h7F
`define SPC_POLY_MMC   16'h1021
`define SPC_POLY_CRC7  16'h0009
`define SPC_POLY_MST   16'h8005
`define SPC_POLY_RSVD  16'h0001
`define SPC_FIFO_FULL  4'h8

// timing
`define SPC_CLK_NS     25
`define SPC_HALF_NS    200
`define SPC_HALF_CYC   ((`SPC_HALF_NS + `SPC_CLK_NS - 1) / `SPC_CLK_NS)

`endif

// ==== logic/spc_pkg.sv ====
package spc_pkg;

	typedef enum logic [1:0] {ENG_IDLE, ENG_SHIFT, ENG_HOLD} spc_eng_phase_t;

	typedef struct packed {
		logic [2:0]     sck_s;
		logic [2:0]     mosi_s;
		logic [2:0]     miso_s;
		logic [2:0]     ss_s;
		logic           sck_f;
		logic           mosi_f;
		logic           miso_f;
		logic           ss_f;
		spc_eng_phase_t st;
		logic [3:0]     div;
		logic [3:0]     cnt;
		logic [7:0]     txsh;
		logic [7:0]     rxsh;
		logic           rd;
		logic           sck_o;
		logic           mosi_o;
		logic           mosi_oe;
		logic           miso_o;
		logic           miso_oe;
		logic           ss_o;
		logic           ss_oe;
		logic           busy;
		logic           began;
		logic           done;
		logic           bit_stb;
		logic           tx_bit;
		logic           rx_bit;
		logic [7:0]     rx_byte;
	} spc_eng_st_t;

	typedef struct packed {
		logic            shared;
		logic            master;
		logic            ss_en;
		logic [4:0]      ss_dly;
		logic            byte_mode;
		logic            fdx;
		logic            ss_man;
		logic            rd_en;
		logic [2:0]      tlen;
		logic [2:0]      rlen;
		logic [2:0]      ien;
		logic [2:0]      flg;
		logic            ferr;
		logic [1:0]      crc_mode;
		logic            crc_en;
		logic            crc_rx;
		logic [15:0]     crc;
		logic [7:0][7:0] txm;
		logic [7:0][7:0] rxm;
		logic [2:0]      twp;
		logic [2:0]      trp;
		logic [2:0]      rwp;
		logic [2:0]      rrp;
		logic [3:0]      tcnt;
		logic [3:0]      rcnt;
		logic            start;
		logic            cur_rd;
		logic [15:0]     rdata;
		logic            irq;
	} spc_ctrl_st_t;

endpackage

// ==== logic/spc_shift_if.sv ====
`timescale 1ns/10ps
interface spc_shift_if;
	logic       start;
	logic       rd;
	logic [3:0] nbits;
	logic [7:0] tx_byte;
	logic       master;
	logic       fdx;
	logic       shared;
	logic       ss_en;
	logic       ss_manual_mode;
	logic       ss_man;
	logic       busy;
	logic       began;
	logic       done;
	logic [7:0] rx_byte;
	logic       bit_stb;
	logic       tx_bit;
	logic       rx_bit;

	modport ctrl (
		output start, rd, nbits, tx_byte, master, fdx, shared, ss_en,
		output ss_manual_mode, ss_man,
		input  busy, began, done, rx_byte, bit_stb, tx_bit, rx_bit
	);

	modport eng (
		input  start, rd, nbits, tx_byte, master, fdx, shared, ss_en,
		input  ss_manual_mode, ss_man,
		output busy, began, done, rx_byte, bit_stb, tx_bit, rx_bit
	);
endinterface

// ==== logic/spc_shifter.sv ====
`timescale 1ns/10ps
`include "spc_cfg.svh"
module spc_shifter
(
	// clock and reset
	input  wire logic clk_in,
	input  wire logic reset_in,
	// control side
	spc_shift_if.eng  bus,
	// serial pins
	input  wire logic sck_in,
	input  wire logic mosi_in,
	input  wire logic miso_in,
	input  wire logic ss_n_in,
	output wire logic sck_out,
	output wire logic sck_oe_out,
	output wire logic mosi_out,
	output wire logic mosi_oe_out,
	output wire logic miso_out,
	output wire logic miso_oe_out,
	output wire logic ss_n_out,
	output wire logic ss_n_oe_out
);
	localparam spc_pkg::spc_eng_st_t RST = '{ss_s: 3'h7, ss_f: 1'b1,
		ss_o: 1'b1, st: spc_pkg::ENG_IDLE, default: '0};
	localparam logic [3:0] HALF_END = 4'(`SPC_HALF_CYC - 1);

	spc_pkg::spc_eng_st_t s;
	spc_pkg::spc_eng_st_t n;
	logic                 din;
	logic                 smp;
	logic                 shf;
	logic                 fin;

	always_comb
	begin
		n = s;
		n.began = 1'b0;
		n.done = 1'b0;
		n.bit_stb = 1'b0;
		smp = 1'b0;
		shf = 1'b0;
		fin = 1'b0;
		// stage [0] is read only by stage [1]
		n.sck_s = {s.sck_s[1:0], sck_in};
		n.mosi_s = {s.mosi_s[1:0], mosi_in};
		n.miso_s = {s.miso_s[1:0], miso_in};
		n.ss_s = {s.ss_s[1:0], ss_n_in};
		if (s.sck_s[1] == s.sck_s[2])
			n.sck_f = s.sck_s[2];
		if (s.mosi_s[1] == s.mosi_s[2])
			n.mosi_f = s.mosi_s[2];
		if (s.miso_s[1] == s.miso_s[2])
			n.miso_f = s.miso_s[2];
		if (s.ss_s[1] == s.ss_s[2])
			n.ss_f = s.ss_s[2];
		// shared line returns on the mosi pin
		din = bus.master ? ((bus.shared && !bus.fdx) ? s.mosi_f : s.miso_f)
			: s.mosi_f;
		case (s.st)
			spc_pkg::ENG_IDLE:
			begin
				n.sck_o = 1'b0;
				if (bus.master ? bus.start : !s.ss_f)
				begin
					n.st = spc_pkg::ENG_SHIFT;
					n.rd = bus.rd;
					n.cnt = bus.nbits;
					n.txsh = bus.tx_byte;
					n.rxsh = 8'h00;
					n.div = 4'h0;
					n.busy = 1'b1;
					n.began = 1'b1;
				end
			end
			spc_pkg::ENG_SHIFT:
			begin
				if (bus.master)
				begin
					n.div = s.div + 4'h1;
					if (s.div == HALF_END)
					begin
						n.div = 4'h0;
						n.sck_o = ~s.sck_o;
						smp = !s.sck_o;
						fin = s.sck_o && (s.cnt == 4'h0);
						shf = s.sck_o && (s.cnt != 4'h0);
					end
				end
				else if (s.ss_f)
				begin
					// frame cut short: no completion
					n.st = spc_pkg::ENG_IDLE;
					n.busy = 1'b0;
				end
				else
				begin
					smp = n.sck_f && !s.sck_f;
					shf = !n.sck_f && s.sck_f;
					fin = smp && (s.cnt == 4'h1);
				end
			end
			default:
			begin
				if (s.ss_f)
				begin
					n.st = spc_pkg::ENG_IDLE;
					n.busy = 1'b0;
				end
			end
		endcase
		if (smp)
		begin
			n.rxsh = {s.rxsh[6:0], din};
			n.cnt = s.cnt - 4'h1;
			n.bit_stb = 1'b1;
			n.tx_bit = s.txsh[7];
			n.rx_bit = din;
		end
		if (shf)
			n.txsh = {s.txsh[6:0], 1'b0};
		if (fin)
		begin
			n.done = 1'b1;
			n.rx_byte = bus.master ? s.rxsh : n.rxsh;
			n.st = bus.master ? spc_pkg::ENG_IDLE : spc_pkg::ENG_HOLD;
			n.busy = !bus.master;
		end
		n.mosi_o = n.txsh[7];
		n.miso_o = n.txsh[7];
		// a read phase on the shared line must release it
		n.mosi_oe = bus.master && !(n.busy ? (n.rd && !bus.fdx) : bus.shared);
		n.miso_oe = !bus.master && n.busy && (bus.fdx || !n.rd);
		if (bus.master && bus.ss_manual_mode)
			n.ss_o = ~bus.ss_man;
		else
			n.ss_o = !(bus.master && n.busy);
		n.ss_oe = bus.master && bus.ss_en;
	end

	always_ff @(posedge clk_in or posedge reset_in)
	begin
		if (reset_in)
			s <= RST;
		else
			s <= n;
	end

	assign bus.busy = s.busy;
	assign bus.began = s.began;
	assign bus.done = s.done;
	assign bus.rx_byte = s.rx_byte;
	assign bus.bit_stb = s.bit_stb;
	assign bus.tx_bit = s.tx_bit;
	assign bus.rx_bit = s.rx_bit;
	assign sck_out = s.sck_o;
	assign sck_oe_out = bus.master;
	assign mosi_out = s.mosi_o;
	assign mosi_oe_out = s.mosi_oe;
	assign miso_out = s.miso_o;
	assign miso_oe_out = s.miso_oe;
	assign ss_n_out = s.ss_o;
	assign ss_n_oe_out = s.ss_oe;
endmodule

// ==== logic/spc_ctrl.sv ====
// Design decision made here: the strobed register port.
`timescale 1ns/10ps
`include "spc_cfg.svh"
// Behaviour
// - byte mode bit picks PIO or block
// - duplex bit; blocked while line shared
// - manual select drives slave select in master mode when delay field is zero
// - read enable clears once a master read starts, direction in slave
// - transmit ready while transmit FIFO not full
// - receive ready while receive data held
// - transmit empty and receive full flags
// - transmit length, zero means eight bits
// - receive length, zero means eight bits
// - three interrupt enables, one per source
// - three interrupt flags readable, transmit and block sticky
// - FIFO error flag on underflow or overflow
// - FIFO init clears the error flag
// - clear register drops transmit and block flags
// - CRC mode selects the polynomial
// - CRC clear presets all ones, reads zero
// - receive CRC picks stream in full duplex
// - data write launches in master, data read drains FIFO
module spc_ctrl
(
	// clock and reset
	input  wire logic        CLK_IN,
	input  wire logic        RESET_IN,
	// register port
	input  wire logic [15:0] ADDR_IN,
	input  wire logic [15:0] WDATA_IN,
	input  wire logic        WR_IN,
	input  wire logic        RD_IN,
	output wire logic [15:0] RDATA_OUT,
	// interrupt request
	output wire logic        IRQ_OUT,
	// serial clock
	input  wire logic        SCK_IN,
	output wire logic        SCK_OUT,
	output wire logic        SCK_OE_OUT,
	// data lines
	input  wire logic        MOSI_IN,
	output wire logic        MOSI_OUT,
	output wire logic        MOSI_OE_OUT,
	input  wire logic        MISO_IN,
	output wire logic        MISO_OUT,
	output wire logic        MISO_OE_OUT,
	// slave select
	input  wire logic        SS_N_IN,
	output wire logic        SS_N_OUT,
	output wire logic        SS_N_OE_OUT
);
	localparam spc_pkg::spc_ctrl_st_t RST = '{shared: `SPC_SHARED_RST,
		ss_dly: `SPC_DLY_RST, crc: `SPC_CRC_PRE, default: '0};

	spc_pkg::spc_ctrl_st_t s;
	spc_pkg::spc_ctrl_st_t n;
	spc_shift_if           sh ();
	logic                  fd;
	logic                  rd_now;
	logic                  init;
	logic                  tclr;
	logic                  bclr;
	logic                  crc_clr;
	logic                  tpush;
	logic                  tpop;
	logic                  rpush;
	logic                  rpop;
	logic                  err;
	logic                  cap;
	logic [2:0]            fset;
	logic                  cbit;
	logic [15:0]           v;

	// zero in a length field stands for a whole byte
	function automatic logic [3:0] spc_bits(input logic [2:0] len);
		begin
			spc_bits = (len == 3'h0) ? 4'h8 : {1'b0, len};
		end
	endfunction

	function automatic logic [15:0] spc_crc_step(input logic [15:0] c,
		input logic b, input logic [1:0] m);
		logic        fb;
		logic [15:0] p;
		begin
			if (m == 2'h1)
			begin
				fb = c[6] ^ b;
				p = fb ? `SPC_POLY_CRC7 : 16'h0000;
				spc_crc_step = {9'h000, c[5:0], 1'b0} ^ p;
			end
			else
			begin
				fb = c[15] ^ b;
				if (m == 2'h0)
					p = `SPC_POLY_MMC;
				else if (m == 2'h2)
					p = `SPC_POLY_MST;
				else
					p = `SPC_POLY_RSVD;
				spc_crc_step = {c[14:0], 1'b0} ^ (fb ? p : 16'h0000);
			end
		end
	endfunction

	always_comb
	begin
		n = s;
		n.start = 1'b0;
		n.rdata = 16'h0000;
		init = 1'b0;
		tclr = 1'b0;
		bclr = 1'b0;
		crc_clr = 1'b0;
		tpush = 1'b0;
		tpop = 1'b0;
		rpush = 1'b0;
		rpop = 1'b0;
		err = 1'b0;
		cap = 1'b0;
		fset = 3'h0;
		cbit = 1'b0;
		v = 16'h0000;
		fd = s.fdx && !s.shared;
		rd_now = s.master ? s.cur_rd : (s.rd_en && !fd);

		// register writes; reserved bits are left alone
		if (WR_IN)
		begin
			if (ADDR_IN == `SPC_A_CFG)
			begin
				n.shared = WDATA_IN[`SPC_CFG_SHARED];
				n.ss_en = WDATA_IN[`SPC_CFG_SS_EN];
				n.ss_dly = WDATA_IN[`SPC_CFG_DLY +: 5];
				// role cannot flip under a running transfer
				if (!sh.busy)
					n.master = WDATA_IN[`SPC_CFG_MASTER];
				if (WDATA_IN[`SPC_CFG_SHARED])
					n.fdx = 1'b0;
			end
			else if (ADDR_IN == `SPC_A_CTL)
			begin
				init = WDATA_IN[`SPC_CTL_INIT];
				n.byte_mode = WDATA_IN[`SPC_CTL_BYTE];
				n.fdx = WDATA_IN[`SPC_CTL_FDX] && !s.shared;
				n.ss_man = WDATA_IN[`SPC_CTL_SSMAN];
				n.rd_en = WDATA_IN[`SPC_CTL_RDEN];
				n.tlen = WDATA_IN[`SPC_CTL_TLEN +: 3];
				n.rlen = WDATA_IN[`SPC_CTL_RLEN +: 3];
			end
			else if (ADDR_IN == `SPC_A_IEN)
			begin
				n.ien = WDATA_IN[2:0];
			end
			else if (ADDR_IN == `SPC_A_CLR)
			begin
				tclr = WDATA_IN[`SPC_IRQ_TX];
				bclr = WDATA_IN[`SPC_IRQ_BLK];
			end
			else if (ADDR_IN == `SPC_A_CRC)
			begin
				n.crc_mode = WDATA_IN[`SPC_CRC_MODE +: 2];
				n.crc_en = WDATA_IN[`SPC_CRC_EN];
				crc_clr = WDATA_IN[`SPC_CRC_CLR];
				n.crc_rx = WDATA_IN[`SPC_CRC_RX];
			end
			else if (ADDR_IN == `SPC_A_DATA)
			begin
				if (s.tcnt != `SPC_FIFO_FULL)
					tpush = 1'b1;
				else
					err = 1'b1;
			end
		end

		// register reads; unmapped addresses answer zero
		if (RD_IN)
		begin
			if (ADDR_IN == `SPC_A_CFG)
			begin
				v[`SPC_CFG_SHARED] = s.shared;
				v[`SPC_CFG_ACTIVE] = s.master && sh.busy;
				v[`SPC_CFG_MASTER] = s.master;
				v[`SPC_CFG_SS_EN] = s.ss_en;
				v[`SPC_CFG_DLY +: 5] = s.ss_dly;
			end
			else if (ADDR_IN == `SPC_A_CTL)
			begin
				v[`SPC_CTL_BYTE] = s.byte_mode;
				v[`SPC_CTL_FDX] = s.fdx;
				v[`SPC_CTL_SSMAN] = s.ss_man;
				v[`SPC_CTL_RDEN] = s.rd_en;
				v[`SPC_CTL_TXRDY] = s.tcnt != `SPC_FIFO_FULL;
				v[`SPC_CTL_RXRDY] = s.rcnt != 4'h0;
				v[`SPC_CTL_TXEMP] = s.tcnt == 4'h0;
				v[`SPC_CTL_RXFUL] = s.rcnt == `SPC_FIFO_FULL;
				v[`SPC_CTL_TLEN +: 3] = s.tlen;
				v[`SPC_CTL_RLEN +: 3] = s.rlen;
			end
			else if (ADDR_IN == `SPC_A_IEN)
			begin
				v[2:0] = s.ien;
			end
			else if (ADDR_IN == `SPC_A_STS)
			begin
				v[`SPC_STS_FERR] = s.ferr;
				v[2:0] = s.flg;
			end
			else if (ADDR_IN == `SPC_A_CRC)
			begin
				v[`SPC_CRC_MODE +: 2] = s.crc_mode;
				v[`SPC_CRC_EN] = s.crc_en;
				v[`SPC_CRC_RX] = s.crc_rx;
				if (s.crc_mode == 2'h1)
				begin
					v[`SPC_CRC_ONE] = s.crc[6:0] != 7'h00;
					v[`SPC_CRC_ZERO] = s.crc[6:0] != `SPC_CRC7_ONES;
				end
				else
				begin
					v[`SPC_CRC_ONE] = s.crc != 16'h0000;
					v[`SPC_CRC_ZERO] = s.crc != `SPC_CRC_PRE;
				end
			end
			else if (ADDR_IN == `SPC_A_DATA)
			begin
				v[7:0] = s.rxm[s.rrp];
				rpop = s.rcnt != 4'h0;
			end
			n.rdata = v;
		end

		// master launches whenever there is work and the shifter is free
		if (s.master && !sh.busy && !s.start && (s.rd_en || s.tcnt != 4'h0))
		begin
			n.start = 1'b1;
			n.cur_rd = s.rd_en && !fd;
		end

		if (sh.began)
		begin
			n.cur_rd = rd_now;
			if (!rd_now)
			begin
				if (s.tcnt != 4'h0)
					tpop = 1'b1;
				else
					err = 1'b1;
			end
			if (s.master && s.cur_rd)
				n.rd_en = 1'b0;
		end

		if (sh.done)
		begin
			cap = fd || s.cur_rd;
			if (cap)
			begin
				if (s.rcnt != `SPC_FIFO_FULL)
					rpush = 1'b1;
				else
					err = 1'b1;
			end
			if (s.byte_mode)
			begin
				fset[`SPC_IRQ_RX] = cap;
				fset[`SPC_IRQ_TX] = fd || !s.cur_rd;
			end
			else
			begin
				// block ends when the queue has drained
				fset[`SPC_IRQ_BLK] = s.tcnt == 4'h0;
			end
		end

		// FIFO pointers; init discards both queues
		if (init)
		begin
			n.twp = 3'h0;
			n.trp = 3'h0;
			n.rwp = 3'h0;
			n.rrp = 3'h0;
			n.tcnt = 4'h0;
			n.rcnt = 4'h0;
		end
		else
		begin
			if (tpush)
			begin
				n.txm[s.twp] = WDATA_IN[7:0];
				n.twp = s.twp + 3'h1;
			end
			if (tpop)
				n.trp = s.trp + 3'h1;
			if (rpush)
			begin
				n.rxm[s.rwp] = sh.rx_byte;
				n.rwp = s.rwp + 3'h1;
			end
			if (rpop)
				n.rrp = s.rrp + 3'h1;
			n.tcnt = s.tcnt + {3'h0, tpush} - {3'h0, tpop};
			n.rcnt = s.rcnt + {3'h0, rpush} - {3'h0, rpop};
		end

		// an error in the same cycle as init still sticks
		n.ferr = (s.ferr && !init) || err;

		// a new event beats a clear in the same cycle
		n.flg[`SPC_IRQ_TX] = (s.flg[`SPC_IRQ_TX] && !tclr)
			|| fset[`SPC_IRQ_TX];
		n.flg[`SPC_IRQ_BLK] = (s.flg[`SPC_IRQ_BLK] && !bclr)
			|| fset[`SPC_IRQ_BLK];
		// receive flag has no clear bit: it drops when the queue empties
		n.flg[`SPC_IRQ_RX] = (s.flg[`SPC_IRQ_RX] && n.rcnt != 4'h0)
			|| fset[`SPC_IRQ_RX];

		cbit = fd ? (s.crc_rx ? sh.rx_bit : sh.tx_bit)
			: (s.cur_rd ? sh.rx_bit : sh.tx_bit);
		if (crc_clr)
			n.crc = `SPC_CRC_PRE;
		else if (sh.bit_stb && s.crc_en)
			n.crc = spc_crc_step(s.crc, cbit, s.crc_mode);

		n.irq = |(n.flg & n.ien);
	end

	always_ff @(posedge CLK_IN or posedge RESET_IN)
	begin
		if (RESET_IN)
			s <= RST;
		else
			s <= n;
	end

	assign sh.start = s.start;
	assign sh.rd = s.master ? s.cur_rd : (s.rd_en && !fd);
	assign sh.nbits = spc_bits(sh.rd ? s.rlen : s.tlen);
	assign sh.tx_byte = s.txm[s.trp];
	assign sh.master = s.master;
	assign sh.fdx = fd;
	assign sh.shared = s.shared;
	assign sh.ss_en = s.ss_en;
	assign sh.ss_manual_mode = s.ss_dly == 5'h00;
	assign sh.ss_man = s.ss_man;

	spc_shifter u_shift
	(
		.clk_in      (CLK_IN),
		.reset_in    (RESET_IN),
		.bus         (sh.eng),
		.sck_in      (SCK_IN),
		.mosi_in     (MOSI_IN),
		.miso_in     (MISO_IN),
		.ss_n_in     (SS_N_IN),
		.sck_out     (SCK_OUT),
		.sck_oe_out  (SCK_OE_OUT),
		.mosi_out    (MOSI_OUT),
		.mosi_oe_out (MOSI_OE_OUT),
		.miso_out    (MISO_OUT),
		.miso_oe_out (MISO_OE_OUT),
		.ss_n_out    (SS_N_OUT),
		.ss_n_oe_out (SS_N_OE_OUT)
	);

	assign RDATA_OUT = s.rdata;
	assign IRQ_OUT = s.irq;
endmodule

// ==== testbench/spc_slave_model.sv ====
`timescale 1ns/10ps
module spc_slave_model
(
	// link pins
	input  wire logic       sck_in,
	input  wire logic       ss_n_in,
	input  wire logic       mosi_in,
	output logic            miso_out,
	// byte to send, bits heard
	input  wire logic [7:0] tx_byte_in,
	output logic [7:0]      rx_byte_out
);
	logic [7:0] sh;
	initial
	begin
		sh          = 8'h00;
		miso_out    = 1'b0;
		rx_byte_out = 8'h00;
	end
	// msb stands as soon as selected
	always @(negedge ss_n_in)
	begin
		sh       = tx_byte_in;
		miso_out = sh[7];
	end
	always @(posedge sck_in)
		if (!ss_n_in)
			rx_byte_out = {rx_byte_out[6:0], mosi_in};
	always @(negedge sck_in)
		if (!ss_n_in)
		begin
			sh       = {sh[6:0], 1'b0};
			miso_out = sh[7];
		end
	// released line flips so a stale bit cannot pass
	always @(posedge ss_n_in)
		miso_out = ~miso_out;
endmodule

// ==== testbench/spc_ctrl_assertions.sv ====
`timescale 1ns/10ps
`include "spc_cfg.svh"
module spc_ctrl_assertions
(
	// clock and reset
	input  wire logic        CLK_IN,
	input  wire logic        RESET_IN,
	// register port
	input  wire logic [15:0] ADDR_IN,
	input  wire logic [15:0] WDATA_IN,
	input  wire logic        WR_IN,
	input  wire logic        RD_IN,
	input  wire logic [15:0] RDATA_OUT,
	// pins watched
	input  wire logic        IRQ_OUT,
	input  wire logic        SS_N_OUT
);
	logic [2:0]  ien;
	logic [15:0] ctl;
	logic [15:0] cfg;
	logic [1:0]  quiet;
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (RESET_IN);
	// shadows of writable fields; quiet counts settle time
	always_ff @(posedge CLK_IN or posedge RESET_IN)
		if (RESET_IN)
		begin
			ien   <= 3'h0;
			ctl   <= 16'h0000;
			cfg   <= 16'h801F;
			quiet <= 2'h0;
		end
		else
		begin
			if (WR_IN && ADDR_IN == `SPC_A_IEN)
				ien <= WDATA_IN[2:0];
			if (WR_IN && ADDR_IN == `SPC_A_CTL)
				ctl <= WDATA_IN;
			if (WR_IN && ADDR_IN == `SPC_A_CFG)
				cfg <= WDATA_IN;
			if (WR_IN && (ADDR_IN == `SPC_A_CFG || ADDR_IN == `SPC_A_CTL))
				quiet <= 2'h0;
			else if (quiet != 2'h3)
				quiet <= quiet + 2'h1;
		end
	sequence s_rd(logic [15:0] a);
		$past(RD_IN && ADDR_IN == a);
	endsequence
	a_rdata_idle: assert property (!$past(RD_IN) |-> RDATA_OUT == 16'h0000)
		else $error("read data outside read cycle");
	a_ien_readback: assert property (s_rd(`SPC_A_IEN) |->
		RDATA_OUT == {13'h0000, $past(ien)}) else $error("enable readback");
	a_mode_readback: assert property (s_rd(`SPC_A_CTL) |->
		(RDATA_OUT & 16'h283F) == ($past(ctl) & 16'h283F))
		else $error("control readback");
	a_fdx_blocked: assert property ($past(RD_IN &&
		ADDR_IN == `SPC_A_CTL && cfg[15]) |-> !RDATA_OUT[12])
		else $error("duplex set on shared line");
	a_ready_flags: assert property (s_rd(`SPC_A_CTL) |->
		(!RDATA_OUT[7] || RDATA_OUT[9]) && (!RDATA_OUT[6] || RDATA_OUT[8]))
		else $error("fifo readiness flags");
	a_crc_clr_zero: assert property (s_rd(`SPC_A_CRC) |->
		!RDATA_OUT[12] && RDATA_OUT[8:0] == 9'h000) else $error("crc clear");
	a_clr_wo: assert property (s_rd(`SPC_A_CLR) |->
		RDATA_OUT == 16'h0000) else $error("clear register read");
	a_sts_reserved: assert property (s_rd(`SPC_A_STS) |->
		RDATA_OUT[15:8] == 8'h00 && RDATA_OUT[6:3] == 4'h0)
		else $error("status reserved bits");
	a_irq_masked: assert property (ien == 3'h0 && $past(ien) == 3'h0
		|-> !IRQ_OUT) else $error("irq with all enables off");
	a_ss_manual: assert property (quiet == 2'h3 && cfg[6] &&
		cfg[4:0] == 5'h00 |-> SS_N_OUT == !ctl[11])
		else $error("manual select level");
endmodule
bind spc_ctrl spc_ctrl_assertions u_chk (.CLK_IN(CLK_IN), .RESET_IN(RESET_IN),
	.ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN),
	.RDATA_OUT(RDATA_OUT), .IRQ_OUT(IRQ_OUT), .SS_N_OUT(SS_N_OUT));

// ==== testbench/tb_top.sv ====
`timescale 1ns/10ps
`include "spc_cfg.svh"
module tb_top;
	logic        CLK_IN = 1'b0;
	logic        RESET_IN = 1'b1;
	logic [15:0] ADDR_IN = 16'h0000;
	logic [15:0] WDATA_IN = 16'h0000;
	logic        WR_IN = 1'b0;
	logic        RD_IN = 1'b0;
	logic        b_sck = 1'b0;
	logic        b_ss = 1'b1;
	logic        b_mosi = 1'b0;
	logic [7:0]  s_tx = 8'h00;
	wire  [15:0] RDATA_OUT;
	wire  [7:0]  s_rx;
	wire         IRQ_OUT, SCK_OUT, SCK_OE_OUT, MOSI_OUT, MOSI_OE_OUT;
	wire         MISO_OUT, MISO_OE_OUT, SS_N_OUT, SS_N_OE_OUT, s_miso;
	int          failures = 0;
	int          tests_run = 0;
	int          cycles = 0;
	// select falls back to b_ss, which idles high; other lines fall back to their outside driver
	wire sck_w  = SCK_OE_OUT ? SCK_OUT : b_sck;
	wire ss_w   = SS_N_OE_OUT ? SS_N_OUT : b_ss;
	wire mosi_w = MOSI_OE_OUT ? MOSI_OUT : b_mosi;
	wire miso_w = MISO_OE_OUT ? MISO_OUT : s_miso;
	logic [79:0] rows [12] = '{
		{`SPC_A_IEN, 16'h0007, `SPC_A_IEN, 16'h0007, 16'hFFFF},
		{`SPC_A_CTL, 16'h2000, `SPC_A_CTL, 16'h2280, 16'hFFFF},
		{`SPC_A_CTL, 16'h1000, `SPC_A_CTL, 16'h0280, 16'hFFFF},
		{`SPC_A_CFG, 16'h0000, `SPC_A_CFG, 16'h0000, 16'hFFFF},
		{`SPC_A_CTL, 16'h103F, `SPC_A_CTL, 16'h12BF, 16'hFFFF},
		{`SPC_A_CRC, 16'h3000, `SPC_A_CRC, 16'h2400, 16'hFFFF},
		{`SPC_A_CRC, 16'h7000, `SPC_A_CRC, 16'h6000, 16'hF9FF},
		{`SPC_A_CRC, 16'hB800, `SPC_A_CRC, 16'hAC00, 16'hFFFF},
		{`SPC_A_CRC, 16'hF000, `SPC_A_CRC, 16'hE400, 16'hFFFF},
		{`SPC_A_CLR, 16'h0003, `SPC_A_CLR, 16'h0000, 16'hFFFF},
		{16'hC0C4, 16'h0005, 16'hC0C4, 16'h0000, 16'hFFFF},
		{`SPC_A_CLR, 16'h0000, `SPC_A_STS, 16'h0000, 16'hFFFF}
	};
	spc_ctrl uut (.CLK_IN(CLK_IN), .RESET_IN(RESET_IN), .ADDR_IN(ADDR_IN),
		.WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN),
		.RDATA_OUT(RDATA_OUT), .IRQ_OUT(IRQ_OUT), .SCK_IN(sck_w),
		.SCK_OUT(SCK_OUT), .SCK_OE_OUT(SCK_OE_OUT), .MOSI_IN(mosi_w),
		.MOSI_OUT(MOSI_OUT), .MOSI_OE_OUT(MOSI_OE_OUT), .MISO_IN(miso_w),
		.MISO_OUT(MISO_OUT), .MISO_OE_OUT(MISO_OE_OUT), .SS_N_IN(ss_w),
		.SS_N_OUT(SS_N_OUT), .SS_N_OE_OUT(SS_N_OE_OUT));
	spc_slave_model u_slave (.sck_in(sck_w), .ss_n_in(ss_w),
		.mosi_in(mosi_w), .miso_out(s_miso), .tx_byte_in(s_tx),
		.rx_byte_out(s_rx));
	always #12.5 CLK_IN = ~CLK_IN;
	task automatic summarize();
		if (failures == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	always @(posedge CLK_IN)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			failures++;
			summarize();
		end
	end
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge CLK_IN);
		WR_IN    <= 1'b1;
		ADDR_IN  <= a;
		WDATA_IN <= d;
		@(posedge CLK_IN);
		WR_IN <= 1'b0;
	endtask
	task automatic rd(input logic [15:0] a, output logic [15:0] q);
		@(posedge CLK_IN);
		RD_IN   <= 1'b1;
		ADDR_IN <= a;
		@(posedge CLK_IN);
		RD_IN <= 1'b0;
		#1 q = RDATA_OUT;
	endtask
	task automatic chk(input logic [15:0] got, exp, m);
		tests_run++;
		if ((got & m) !== (exp & m))
		begin
			failures++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic rc(input logic [15:0] a, exp, m);
		logic [15:0] q;
		rd(a, q);
		chk(q, exp, m);
	endtask
	// poll with a bound; a hang shows as a mismatch
	task automatic wt(input logic [15:0] a, m, v);
		logic [15:0] q;
		q = ~v;
		for (int i = 0; i < 300 && (q & m) !== v; i++)
			rd(a, q);
		chk(q, v, m);
	endtask
	// link runs only inside the frame, off the system clock edges
	task automatic frame(input logic [7:0] d, output logic [7:0] g);
		#3 b_ss = 1'b0;
		#300;
		for (int i = 7; i >= 0; i--)
		begin
			b_mosi = d[i];
			#100 g[i] = miso_w;
			b_sck = 1'b1;
			#100 b_sck = 1'b0;
		end
		#300 b_ss = 1'b1;
		b_mosi = ~b_mosi;
		#300;
	endtask
	initial
	begin
		logic [7:0] g;
		repeat (10) @(posedge CLK_IN);
		chk({13'h0, IRQ_OUT, SS_N_OUT, SCK_OE_OUT}, 16'h0002, 16'h0007);
		RESET_IN <= 1'b0;
		rc(`SPC_A_CFG, 16'h801F, 16'hFFFF);
		rc(`SPC_A_CTL, 16'h0280, 16'hFFFF);
		foreach (rows[i])
		begin
			wr(rows[i][79:64], rows[i][63:48]);
			rc(rows[i][47:32], rows[i][31:16], rows[i][15:0]);
		end
		// master, full byte, full duplex, irq on
		wr(`SPC_A_CFG, 16'h0061);
		wr(`SPC_A_IEN, 16'h0006);
		wr(`SPC_A_CTL, 16'h3000);
		s_tx = 8'hA5;
		wr(`SPC_A_DATA, 16'h003C);
		wt(`SPC_A_STS, 16'h0002, 16'h0002);
		chk({8'h00, s_rx}, 16'h003C, 16'h00FF);
		rc(`SPC_A_STS, 16'h0006, 16'hFFFF);
		chk({15'h0, IRQ_OUT}, 16'h0001, 16'h0001);
		rc(`SPC_A_CTL, 16'h3380, 16'hFFFF);
		rc(`SPC_A_DATA, 16'h00A5, 16'h00FF);
		wr(`SPC_A_CLR, 16'h0002);
		rc(`SPC_A_STS, 16'h0000, 16'hFFFF);
		rc(`SPC_A_CRC, 16'hE600, 16'hFFFF);
		// five-bit frame with interrupts masked
		wr(`SPC_A_IEN, 16'h0000);
		wr(`SPC_A_CTL, 16'h302D);
		s_tx = 8'hB8;
		wr(`SPC_A_DATA, 16'h00A8);
		wt(`SPC_A_STS, 16'h0002, 16'h0002);
		chk({11'h0, s_rx[4:0]}, 16'h0015, 16'h001F);
		chk({15'h0, IRQ_OUT}, 16'h0000, 16'h0001);
		rc(`SPC_A_DATA, 16'h0017, 16'h001F);
		wr(`SPC_A_CLR, 16'h0003);
		// master read phase without data write
		s_tx = 8'h5A;
		wr(`SPC_A_CTL, 16'h2400);
		wt(`SPC_A_STS, 16'h0004, 16'h0004);
		rc(`SPC_A_CTL, 16'h0000, 16'h0400);
		rc(`SPC_A_DATA, 16'h005A, 16'h00FF);
		wt(`SPC_A_CFG, 16'h0080, 16'h0000);
		// manual select
		wr(`SPC_A_CFG, 16'h0060);
		wr(`SPC_A_CTL, 16'h0800);
		repeat (4) @(posedge CLK_IN);
		#1 chk({15'h0, SS_N_OUT}, 16'h0000, 16'h0001);
		chk({12'h0, SS_N_OE_OUT, SCK_OE_OUT, MOSI_OE_OUT, MISO_OE_OUT},
			16'h000E, 16'h000F);
		wr(`SPC_A_CTL, 16'h0000);
		repeat (4) @(posedge CLK_IN);
		#1 chk({15'h0, SS_N_OUT}, 16'h0001, 16'h0001);
		// block mode: completion flag and its clear
		wr(`SPC_A_CTL, 16'h1000);
		wr(`SPC_A_IEN, 16'h0001);
		wr(`SPC_A_DATA, 16'h0055);
		wt(`SPC_A_STS, 16'h0001, 16'h0001);
		chk({15'h0, IRQ_OUT}, 16'h0001, 16'h0001);
		wr(`SPC_A_CLR, 16'h0001);
		rc(`SPC_A_STS, 16'h0000, 16'h0007);
		// slave: overfill, init, one frame, then underflow
		wr(`SPC_A_CFG, 16'h0000);
		wr(`SPC_A_CTL, 16'h7000);
		for (int i = 0; i < 9; i++)
			wr(`SPC_A_DATA, 16'h0096);
		rc(`SPC_A_CTL, 16'h3000, 16'h3280);
		rc(`SPC_A_STS, 16'h0080, 16'h0080);
		wr(`SPC_A_CTL, 16'h7000);
		rc(`SPC_A_STS, 16'h0000, 16'h0080);
		rc(`SPC_A_CTL, 16'h3280, 16'h3280);
		wr(`SPC_A_DATA, 16'h0096);
		frame(8'h69, g);
		chk({8'h00, g}, 16'h0096, 16'h00FF);
		rc(`SPC_A_DATA, 16'h0069, 16'h00FF);
		frame(8'h00, g);
		rc(`SPC_A_CTL, 16'h0080, 16'h0080);
		rc(`SPC_A_STS, 16'h0080, 16'h0080);
		summarize();
	end
endmodule
